/* File: common/rtcf_pkg.sv */
// shared constants for the rtc status and flag block
package rtcf_pkg;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0c;
  localparam logic [7:0] ADDR_INT_STAT = 8'h40;
  localparam logic [7:0] ADDR_INT_CLR  = 8'h44;
  localparam logic [7:0] ADDR_INT_EN   = 8'h48;

  // status word field positions
  localparam int B_CALIB  = 16;
  localparam int B_TAMP1  = 14;
  localparam int B_TAMP0  = 13;
  localparam int B_STOVF  = 12;
  localparam int B_STAMP  = 11;
  localparam int B_ALARM  = 8;
  localparam int B_INITRQ = 7;
  localparam int B_INITST = 6;
  localparam int B_SYNC   = 5;
  localparam int B_YEAR   = 4;
  localparam int B_SHIFT  = 3;
  localparam int B_WOK    = 0;

  // status reset value and reserved bits that keep it
  localparam logic [31:0] STAT_RESET     = 32'h0000_0007;
  localparam logic [31:0] STAT_RSVD_ONES = 32'h0000_0006;

  // control word field positions
  localparam int C_ALARM_EN = 8;
  localparam int C_BYPASS   = 5;

  // interrupt status layout
  localparam int INT_W   = 4;
  localparam int I_ALARM = 0;
  localparam int I_STAMP = 1;
  localparam int I_TAMP0 = 2;
  localparam int I_TAMP1 = 3;
  localparam logic [INT_W-1:0] INT_RESET = 4'h0;

  // shadow refresh period in kernel clock periods
  localparam int         SYNC_PERIODS = 2;
  localparam logic [0:0] SYNC_LAST    = 1'(SYNC_PERIODS - 1);

  // misc reset values
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [7:0]  YEAR_DEF  = 8'h00;

endpackage : rtcf_pkg

/* File: rtl/rtcf_status.sv */
// Strobed register access was left to the implementer.
`timescale 1ns/1ps

module rtcf_status
  import rtcf_pkg::*;
(
  input  wire logic        mclk,            // bus clock
  input  wire logic        reset_n,         // system reset
  input  wire logic        bkp_reset_n,     // backup domain reset
  input  wire logic [7:0]  addr,            // register byte address
  input  wire logic [31:0] wdata,           // write data
  input  wire logic        wr_en,           // write strobe
  input  wire logic        rd_en,           // read strobe
  output logic      [31:0] rdata,           // read data, next cycle
  input  wire logic        wp_unlocked,     // write protection open
  input  wire logic        rtc_kernel_clock, // kernel clock pin
  input  wire logic        tamper_input_0,  // tamper pin 0
  input  wire logic        tamper_input_1,  // tamper pin 1
  input  wire logic        stamp_event,     // time-stamp detected
  input  wire logic        alarm_match,     // calendar equals alarm
  input  wire logic        calib_write,     // smooth calib written
  input  wire logic        calib_applied,   // calib taken into use
  input  wire logic        shift_op_busy,   // shift operation pends
  input  wire logic [7:0]  year_field,      // calendar year bcd
  input  wire logic [31:0] live_time,       // live calendar time
  input  wire logic [31:0] live_date,       // live calendar date
  output logic      [31:0] cal_time_rd,     // time seen by reads
  output logic      [31:0] cal_date_rd,     // date seen by reads
  output logic             counters_stop,   // hold calendar counters
  output logic             cal_write_ok,    // calendar writable
  output logic             alarm0_write_ok, // alarm writable
  output logic             irq              // interrupt level
);

  // system-reset flops also cleared by backup reset; bus read and interrupt flops see reset_n only
  logic rst_all_n;
  assign rst_all_n = reset_n & bkp_reset_n;

  // backed up status flags
  logic calib_pending_flag_q, calib_pending_flag_d;
  logic tamper1_flag_q,       tamper1_flag_d;
  logic tamper0_flag_q,       tamper0_flag_d;
  logic stamp_overflow_flag_q, stamp_overflow_flag_d;
  logic stamp_flag_q,         stamp_flag_d;
  logic alarm0_match_flag_q,  alarm0_match_flag_d;
  logic year_configured_q;
  logic shift_pending_q;
  logic alarm0_write_ok_q;
  logic rsvd_hi_q,            rsvd_lo_q;

  // flags under system reset
  logic init_request_q,       init_request_d;
  logic init_state_flag_q,    init_state_flag_d;
  logic shadow_synced_flag_q, shadow_synced_flag_d;

  // control bits
  logic alarm0_enable_q,      alarm0_enable_d;
  logic shadow_bypass_q,      shadow_bypass_d;

  // shadow calendar and read path
  logic [31:0] shadow_time_q, shadow_date_q;
  logic [31:0] cal_time_rd_q, cal_date_rd_q;

  // interrupt registers
  logic [INT_W-1:0] int_stat_q, int_stat_d;
  logic [INT_W-1:0] int_en_q;
  logic [INT_W-1:0] int_evt;
  logic             irq_q;

  // bus read data
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;
  logic [31:0] stat_word;

  // pin synchronisers and edge stages
  logic k_s1_q, k_s2_q, k_s3_q;
  logic t0_s1_q, t0_s2_q, t0_s3_q;
  logic t1_s1_q, t1_s2_q, t1_s3_q;
  logic [0:0] kcnt_q;

  // rising edge of a synchronised level
  function automatic logic rise(input logic now, input logic last);
    rise = now & ~last;
  endfunction : rise

  // write decode
  logic wr_status, wr_ctrl, wr_int_clr, wr_int_en;
  logic wr_locked;
  assign wr_status  = wr_en && (addr == ADDR_STATUS);
  assign wr_ctrl    = wr_en && (addr == ADDR_CTRL);
  assign wr_int_clr = wr_en && (addr == ADDR_INT_CLR);
  assign wr_int_en  = wr_en && (addr == ADDR_INT_EN);
  assign wr_locked  = wr_status && wp_unlocked;

  // clears on written zero, ones leave flags alone
  logic clr_tamp1, clr_tamp0, clr_stovf, clr_stamp, clr_alarm;
  logic clr_sync;
  assign clr_tamp1 = wr_status && !wdata[B_TAMP1];
  assign clr_tamp0 = wr_status && !wdata[B_TAMP0];
  assign clr_stovf = wr_status && !wdata[B_STOVF];
  assign clr_stamp = wr_status && !wdata[B_STAMP];
  assign clr_alarm = wr_status && !wdata[B_ALARM];
  assign clr_sync  = wr_locked && !wdata[B_SYNC];

  // kernel clock edges and shadow refresh tick
  logic kedge, sync_tick, sync_block;
  logic tamp0_rise, tamp1_rise;
  assign kedge      = rise(k_s2_q, k_s3_q);
  assign sync_tick  = kedge && (kcnt_q == SYNC_LAST);
  assign sync_block = init_request_q | shift_pending_q |
                      shadow_bypass_q;
  assign tamp0_rise = rise(t0_s2_q, t0_s3_q);
  assign tamp1_rise = rise(t1_s2_q, t1_s3_q);

  // hardware set wins over software clear
  assign tamper1_flag_d  = tamp1_rise | (tamper1_flag_q & ~clr_tamp1);
  assign tamper0_flag_d  = tamp0_rise | (tamper0_flag_q & ~clr_tamp0);
  assign stamp_flag_d    = stamp_event | (stamp_flag_q & ~clr_stamp);
  assign stamp_overflow_flag_d = (stamp_event & stamp_flag_q) |
                                 (stamp_overflow_flag_q & ~clr_stovf);
  assign alarm0_match_flag_d = alarm_match |
                               (alarm0_match_flag_q & ~clr_alarm);
  assign calib_pending_flag_d = (calib_write & ~init_request_q) |
                                (calib_pending_flag_q & ~calib_applied);

  // init handshake and sync flag
  assign init_request_d = wr_locked ? wdata[B_INITRQ] : init_request_q;
  assign init_state_flag_d = init_request_q &
                             (init_state_flag_q | kedge);
  assign shadow_synced_flag_d = !sync_block &&
                                (sync_tick ||
                                 (shadow_synced_flag_q && !clr_sync));

  // control register, write protected
  assign alarm0_enable_d = (wr_ctrl && wp_unlocked) ?
                           wdata[C_ALARM_EN] : alarm0_enable_q;
  assign shadow_bypass_d = (wr_ctrl && wp_unlocked) ?
                           wdata[C_BYPASS] : shadow_bypass_q;

  // interrupt status, set wins over write-one clear
  assign int_evt[I_ALARM] = alarm_match;
  assign int_evt[I_STAMP] = stamp_event;
  assign int_evt[I_TAMP0] = tamp0_rise;
  assign int_evt[I_TAMP1] = tamp1_rise;
  assign int_stat_d = int_evt |
                      (int_stat_q & ~(wr_int_clr ?
                                      wdata[INT_W-1:0] : INT_RESET));

  // status word as read
  always_comb begin
    stat_word           = STAT_RSVD_ONES & {30'h0, rsvd_hi_q, 1'b0} |
                          STAT_RSVD_ONES & {29'h0, rsvd_lo_q, 2'h0};
    stat_word[B_CALIB]  = calib_pending_flag_q;
    stat_word[B_TAMP1]  = tamper1_flag_q;
    stat_word[B_TAMP0]  = tamper0_flag_q;
    stat_word[B_STOVF]  = stamp_overflow_flag_q;
    stat_word[B_STAMP]  = stamp_flag_q;
    stat_word[B_ALARM]  = alarm0_match_flag_q;
    stat_word[B_INITRQ] = init_request_q;
    stat_word[B_INITST] = init_state_flag_q;
    stat_word[B_SYNC]   = shadow_synced_flag_q;
    stat_word[B_YEAR]   = year_configured_q;
    stat_word[B_SHIFT]  = shift_pending_q;
    stat_word[B_WOK]    = alarm0_write_ok_q;
  end

  // read select, unmapped reads as zero
  logic [31:0] ctrl_word;
  always_comb begin
    ctrl_word             = WORD_ZERO;
    ctrl_word[C_ALARM_EN] = alarm0_enable_q;
    ctrl_word[C_BYPASS]   = shadow_bypass_q;
  end
  assign rd_mux = (addr == ADDR_STATUS)   ? stat_word :
                  (addr == ADDR_CTRL)     ? ctrl_word :
                  (addr == ADDR_INT_STAT) ? {28'h0, int_stat_q} :
                  (addr == ADDR_INT_EN)   ? {28'h0, int_en_q} :
                  WORD_ZERO;

  // pin synchronisers, backup domain: system reset must not fake an edge
  always_ff @(posedge mclk or negedge bkp_reset_n) begin
    if (!bkp_reset_n) begin
      {k_s1_q, k_s2_q, k_s3_q}    <= 3'h0;
      {t0_s1_q, t0_s2_q, t0_s3_q} <= 3'h0;
      {t1_s1_q, t1_s2_q, t1_s3_q} <= 3'h0;
    end else begin
      {k_s1_q, k_s2_q, k_s3_q}    <= {rtc_kernel_clock, k_s1_q, k_s2_q};
      {t0_s1_q, t0_s2_q, t0_s3_q} <= {tamper_input_0, t0_s1_q, t0_s2_q};
      {t1_s1_q, t1_s2_q, t1_s3_q} <= {tamper_input_1, t1_s1_q, t1_s2_q};
    end
  end

  // kernel period counter
  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      kcnt_q <= 1'h0;
    end else if (kedge) begin
      kcnt_q <= kcnt_q + 1'h1;
    end
  end

  // system-reset flags
  always_ff @(posedge mclk or negedge rst_all_n) begin
    if (!rst_all_n) begin
      init_request_q       <= STAT_RESET[B_INITRQ];
      init_state_flag_q    <= STAT_RESET[B_INITST];
      shadow_synced_flag_q <= STAT_RESET[B_SYNC];
    end else begin
      init_request_q       <= init_request_d;
      init_state_flag_q    <= init_state_flag_d;
      shadow_synced_flag_q <= shadow_synced_flag_d;
    end
  end

  // backup flags, untouched by system reset
  always_ff @(posedge mclk or negedge bkp_reset_n) begin
    if (!bkp_reset_n) begin
      calib_pending_flag_q  <= STAT_RESET[B_CALIB];
      tamper1_flag_q        <= STAT_RESET[B_TAMP1];
      tamper0_flag_q        <= STAT_RESET[B_TAMP0];
      stamp_overflow_flag_q <= STAT_RESET[B_STOVF];
      stamp_flag_q          <= STAT_RESET[B_STAMP];
      alarm0_match_flag_q   <= STAT_RESET[B_ALARM];
      year_configured_q     <= STAT_RESET[B_YEAR];
      shift_pending_q       <= STAT_RESET[B_SHIFT];
      alarm0_write_ok_q     <= STAT_RESET[B_WOK];
      rsvd_hi_q             <= STAT_RESET[2];
      rsvd_lo_q             <= STAT_RESET[1];
    end else begin
      calib_pending_flag_q  <= calib_pending_flag_d;
      tamper1_flag_q        <= tamper1_flag_d;
      tamper0_flag_q        <= tamper0_flag_d;
      stamp_overflow_flag_q <= stamp_overflow_flag_d;
      stamp_flag_q          <= stamp_flag_d;
      alarm0_match_flag_q   <= alarm0_match_flag_d;
      year_configured_q     <= (year_field != YEAR_DEF);
      shift_pending_q       <= shift_op_busy;
      alarm0_write_ok_q     <= ~alarm0_enable_q;
    end
  end

  // control and shadow calendar, backup domain
  always_ff @(posedge mclk or negedge bkp_reset_n) begin
    if (!bkp_reset_n) begin
      alarm0_enable_q <= 1'b0;
      shadow_bypass_q <= 1'b0;
      shadow_time_q   <= WORD_ZERO;
      shadow_date_q   <= WORD_ZERO;
      cal_time_rd_q   <= WORD_ZERO;
      cal_date_rd_q   <= WORD_ZERO;
    end else begin
      alarm0_enable_q <= alarm0_enable_d;
      shadow_bypass_q <= shadow_bypass_d;
      if (sync_tick && !sync_block) begin
        shadow_time_q <= live_time;
        shadow_date_q <= live_date;
      end
      cal_time_rd_q <= shadow_bypass_q ? live_time : shadow_time_q;
      cal_date_rd_q <= shadow_bypass_q ? live_date : shadow_date_q;
    end
  end

  // bus read data and interrupt logic
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q    <= WORD_ZERO;
      int_stat_q <= INT_RESET;
      int_en_q   <= INT_RESET;
      irq_q      <= 1'b0;
    end else begin
      rdata_q    <= rd_en ? rd_mux : WORD_ZERO;
      int_stat_q <= int_stat_d;
      if (wr_int_en) begin
        int_en_q <= wdata[INT_W-1:0];
      end
      irq_q      <= |(int_stat_q & int_en_q);
    end
  end

  // outputs straight from flops
  assign rdata           = rdata_q;
  assign cal_time_rd     = cal_time_rd_q;
  assign cal_date_rd     = cal_date_rd_q;
  assign counters_stop   = init_request_q;
  assign cal_write_ok    = init_state_flag_q;
  assign alarm0_write_ok = alarm0_write_ok_q;
  assign irq             = irq_q;

  // checks on flag behaviour
  a_stamp_set: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    stamp_event |=> stamp_flag_q)
    else $error("stamp flag not set");

  a_stamp_ovf: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    stamp_event && stamp_flag_q |=> stamp_overflow_flag_q)
    else $error("stamp overflow missed");

  a_tamper_set: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    tamp0_rise || tamp1_rise |=>
      (tamper0_flag_q || !$past(tamp0_rise)) &&
      (tamper1_flag_q || !$past(tamp1_rise)))
    else $error("tamper flag not set");

  a_one_keeps: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    wr_status && wdata[B_ALARM] && alarm0_match_flag_q
      |=> alarm0_match_flag_q)
    else $error("write one cleared flag");

  a_alarm_clear: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    wr_status && !wp_unlocked && !wdata[B_ALARM] && !alarm_match
      |=> !alarm0_match_flag_q)
    else $error("alarm flag clear refused");

  a_lock_holds: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    wr_status && !wp_unlocked |=> $stable(init_request_q))
    else $error("locked write changed init request");

  a_sync_block: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    sync_block |=> !shadow_synced_flag_q)
    else $error("sync flag set while blocked");

  a_sync_tick: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    sync_tick && !sync_block |=>
      shadow_synced_flag_q && shadow_time_q == $past(live_time))
    else $error("shadow refresh missed");

  a_calib_set: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    calib_write && !init_request_q |=> calib_pending_flag_q)
    else $error("calibration pending not set");

  a_init_state: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    !init_request_q |=> !init_state_flag_q ##0 !cal_write_ok)
    else $error("init state without request");

  a_alarm_wok: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    alarm0_enable_q |=> !alarm0_write_ok)
    else $error("alarm write allowed while enabled");

  a_bypass_read: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    shadow_bypass_q |=> cal_time_rd == $past(live_time))
    else $error("bypass read not live");

  a_shift_mirror: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    shift_op_busy |=> shift_pending_q)
    else $error("shift pending not shown");

  a_year_mark: assert property (
    @(posedge mclk) disable iff (!rst_all_n)
    (year_field != YEAR_DEF) |=> year_configured_q)
    else $error("year configured not shown");

endmodule : rtcf_status

/* File: dv/tb.sv */
`timescale 1ns/1ps

module tb;
  import rtcf_pkg::*;

  logic        mclk = 1'b0;
  logic        reset_n, bkp_reset_n, wr_en, rd_en, wp_unlocked;
  logic        rtc_kernel_clock, tamper_input_0, tamper_input_1;
  logic        stamp_event, alarm_match, calib_write, calib_applied;
  logic        shift_op_busy, kclk_run;
  logic        counters_stop, cal_write_ok, alarm0_write_ok, irq;
  logic [7:0]  addr, year_field;
  logic [31:0] wdata, rdata, live_time, live_date, cal_time_rd;
  logic [31:0] cal_date_rd, exp_stat, t_old;
  logic [3:0]  exp_int, exp_en;
  int          mismatches = 0;
  int          checks = 0;

  rtcf_status u_rtcf_status (
    .mclk(mclk), .reset_n(reset_n), .bkp_reset_n(bkp_reset_n),
    .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .wp_unlocked(wp_unlocked),
    .rtc_kernel_clock(rtc_kernel_clock),
    .tamper_input_0(tamper_input_0), .tamper_input_1(tamper_input_1),
    .stamp_event(stamp_event), .alarm_match(alarm_match),
    .calib_write(calib_write), .calib_applied(calib_applied),
    .shift_op_busy(shift_op_busy), .year_field(year_field),
    .live_time(live_time), .live_date(live_date),
    .cal_time_rd(cal_time_rd), .cal_date_rd(cal_date_rd),
    .counters_stop(counters_stop), .cal_write_ok(cal_write_ok),
    .alarm0_write_ok(alarm0_write_ok), .irq(irq)
  );

  // bus clock and a free kernel clock of unrelated phase
  always #2 mclk = ~mclk;
  always begin
    #7;
    if (kclk_run) rtc_kernel_clock = ~rtc_kernel_clock;
  end

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;                 // whole words only
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // read strobe for one cycle, data checked in the following cycle
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask : rdc

  // status write through the model: lock and clear-on-zero handling
  task automatic wstat(input logic [31:0] d);
    if (wp_unlocked) begin
      exp_stat[B_INITRQ] = d[B_INITRQ];
      exp_stat[B_SYNC]   = exp_stat[B_SYNC] & d[B_SYNC];
    end
    exp_stat = exp_stat & (d | 32'hffff_80ff);
    wr(ADDR_STATUS, d);
  endtask : wstat

  // one-cycle event pulse plus its effect on the model
  task automatic ev(input int k);
    @(posedge mclk);
    case (k)
      0: stamp_event <= 1'b1;
      1: alarm_match <= 1'b1;
      2: calib_write <= 1'b1;
      default: calib_applied <= 1'b1;
    endcase
    @(posedge mclk);
    {stamp_event, alarm_match, calib_write, calib_applied} <= 4'h0;
    if (k == 0) begin
      exp_stat[B_STOVF] = exp_stat[B_STOVF] | exp_stat[B_STAMP];
      exp_stat[B_STAMP] = 1'b1;
      exp_int[I_STAMP]  = 1'b1;
    end
    if (k == 1) begin
      exp_stat[B_ALARM] = 1'b1;
      exp_int[I_ALARM]  = 1'b1;
    end
    if (k == 2 && !exp_stat[B_INITRQ]) exp_stat[B_CALIB] = 1'b1;
    if (k == 3) exp_stat[B_CALIB] = 1'b0;
  endtask : ev

  // hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial begin
    void'($urandom(92758));
    {reset_n, bkp_reset_n, wr_en, rd_en, wp_unlocked} = 5'h0;
    {rtc_kernel_clock, tamper_input_0, tamper_input_1, kclk_run} = 4'h0;
    {stamp_event, alarm_match, calib_write, calib_applied} = 4'h0;
    shift_op_busy = 1'b0;
    addr = 8'h00;
    wdata = 32'h0000_0000;
    year_field = YEAR_DEF;
    live_time = $urandom;
    live_date = $urandom;
    exp_stat = STAT_RESET;
    exp_int = INT_RESET;
    exp_en = 4'h0;
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    bkp_reset_n <= 1'b1;
    rdc(ADDR_STATUS, exp_stat);
    rdc(8'h20, 32'h0000_0000);
    wr(ADDR_INT_EN, 32'h0000_000f);
    exp_en = 4'hf;
    ev(0);
    rdc(ADDR_STATUS, exp_stat);
    ev(0);
    ev(1);
    ev(2);
    tamper_input_0 <= 1'b1;
    tamper_input_1 <= 1'b1;
    exp_stat[B_TAMP0] = 1'b1;
    exp_stat[B_TAMP1] = 1'b1;
    exp_int = 4'hf;
    cyc(8);
    rdc(ADDR_STATUS, exp_stat);
    chk(32'(irq), 32'h1);
    rdc(ADDR_INT_STAT, 32'(exp_int));
    rdc(ADDR_INT_EN, 32'(exp_en));
    wr(ADDR_INT_CLR, 32'h0000_000f);
    wr(ADDR_INT_EN, 32'h0000_0000);
    exp_int = 4'h0;
    exp_en = 4'h0;
    rdc(ADDR_INT_EN, 32'(exp_en));
    ev(0);
    cyc(2);
    chk(32'(irq), 32'h0);
    rdc(ADDR_INT_STAT, 32'(exp_int));
    wr(ADDR_INT_EN, 32'h0000_0002);
    exp_en = 4'h2;
    cyc(2);
    chk(32'(irq), 32'h1);
    rdc(ADDR_INT_EN, 32'(exp_en));
    wr(ADDR_INT_CLR, 32'h0000_0002);
    exp_int[I_STAMP] = 1'b0;
    cyc(2);
    chk(32'(irq), 32'h0);
    rdc(ADDR_INT_STAT, 32'(exp_int));
    // locked writes: ones keep flags, zeros in 14:8 still clear
    wstat(32'hffff_ffff);
    rdc(ADDR_STATUS, exp_stat);
    wstat(32'h0000_0000);
    rdc(ADDR_STATUS, exp_stat);
    ev(3);
    year_field <= 8'($urandom_range(8'h99, 8'h01));
    exp_stat[B_YEAR] = 1'b1;
    cyc(2);
    rdc(ADDR_STATUS, exp_stat);
    // init handshake through the kernel clock
    wp_unlocked <= 1'b1;
    kclk_run = 1'b1;
    cyc(1);
    wstat(32'h0000_79a0);
    cyc(30);
    exp_stat[B_INITST] = 1'b1;
    chk(32'(counters_stop), 32'h1);
    chk(32'(cal_write_ok), 32'h1);
    ev(2);
    rdc(ADDR_STATUS, exp_stat);
    wstat(32'h0000_7920);
    cyc(30);
    exp_stat[B_INITST] = 1'b0;
    exp_stat[B_SYNC] = 1'b1;
    chk(32'(counters_stop), 32'h0);
    chk(32'(cal_write_ok), 32'h0);
    rdc(ADDR_STATUS, exp_stat);
    chk(cal_time_rd, live_time);
    chk(cal_date_rd, live_date);
    // shadow holds while kernel is still, bypass shows live values
    kclk_run = 1'b0;
    cyc(10);
    t_old = live_time;
    live_time <= $urandom;
    cyc(4);
    chk(cal_time_rd, t_old);
    wr(ADDR_CTRL, 32'(1) << C_BYPASS);
    cyc(3);
    chk(cal_time_rd, live_time);
    exp_stat[B_SYNC] = 1'b0;
    rdc(ADDR_STATUS, exp_stat);
    wr(ADDR_CTRL, 32'h0000_0000);
    kclk_run = 1'b1;
    cyc(30);
    exp_stat[B_SYNC] = 1'b1;
    chk(cal_time_rd, live_time);
    shift_op_busy <= 1'b1;
    cyc(3);
    exp_stat[B_SHIFT] = 1'b1;
    exp_stat[B_SYNC] = 1'b0;
    rdc(ADDR_STATUS, exp_stat);
    shift_op_busy <= 1'b0;
    cyc(30);
    exp_stat[B_SHIFT] = 1'b0;
    exp_stat[B_SYNC] = 1'b1;
    rdc(ADDR_STATUS, exp_stat);
    // alarm enable withdraws alarm write permission
    wr(ADDR_CTRL, 32'(1) << C_ALARM_EN);
    cyc(2);
    exp_stat[B_WOK] = 1'b0;
    chk(32'(alarm0_write_ok), 32'h0);
    rdc(ADDR_STATUS, exp_stat);
    wr(ADDR_CTRL, 32'h0000_0000);
    cyc(2);
    exp_stat[B_WOK] = 1'b1;
    chk(32'(alarm0_write_ok), 32'h1);
    // system reset in init mode keeps all status bits but init and sync, and clears interrupt status
    ev(0);
    wstat(32'h0000_79a0);
    cyc(30);
    kclk_run = 1'b0;
    cyc(10);
    @(posedge mclk);
    reset_n <= 1'b0;
    cyc(3);
    @(posedge mclk);
    reset_n <= 1'b1;
    exp_stat[B_INITRQ] = 1'b0;
    exp_stat[B_INITST] = 1'b0;
    exp_stat[B_SYNC] = 1'b0;
    exp_int = 4'h0;
    rdc(ADDR_STATUS, exp_stat);
    chk(32'(counters_stop), 32'h0);
    rdc(ADDR_INT_STAT, 32'(exp_int));
    report_and_stop();
  end

endmodule : tb
